/* File: inc/pgr_pkg.sv */
package pgr_pkg;
  // ====================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h04;
  localparam logic [7:0] ADDR_GRAY_CTRL = 8'h08;
  localparam logic [7:0] ADDR_THRESH = 8'h0C;
  localparam logic [7:0] ADDR_RX_DATA = 8'h10;
  // ====================================================
  // Interrupt bit positions
  localparam int BIT_RX_ERR = 3;
  localparam int BIT_TX_ERR = 2;
  localparam int BIT_RX_LVL = 1;
  localparam int BIT_TX_LVL = 0;
  // ====================================================
  // Gray control and threshold fields
  localparam int GRAY_EN_BIT = 0;
  localparam int GRAY_CLR_BIT = 1;
  localparam int GRAY_FLUSH_BIT = 2;
  localparam int GRAY_BUF_LSB = 4;
  localparam int GRAY_FLUSHED_LSB = 10;
  localparam int GRAY_WORDS_LSB = 16;
  localparam int THR_TX_LSB = 8;
  // ====================================================
  // Reset values and sizes
  localparam logic [3:0] INT_RESET = 4'h0;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [6:0] RX_THR_RESET = 7'h01;
  localparam logic [6:0] TX_THR_RESET = 7'h01;
  // ====================================================
  // Bus request carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pgr_bus_req_t;
  typedef enum logic [1:0] {PGR_IDLE, PGR_WAIT} pgr_flush_state_t;
endpackage : pgr_pkg

/* File: src/pgr_core.sv */
// Contract
// - RX error raises interrupt when enabled
// - TX error raises interrupt when enabled
// - RX level at/above threshold interrupts
// - TX level below threshold interrupts
// - Status bits 3:0 report four events
// - Write one clears status, zero ignored
// - Enable bit selects data/strobe receive mode
// - Count bits, push word at 32
// - Flush pushes partial word zero padded
// - Flushed count records valid bits
// - Flush bit reads zero until done
// - Clear bit resets gray logic, sticky
// - Gray field reports FIFO word count

// ====================================================
// Receive FIFO
module pgr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [CW-1:0] count_out
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] wp_r;
  logic [$clog2(DEPTH)-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_r != CW'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rp_r];
  assign count_out = cnt_r;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || clr_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data_in;
        wp_r <= (wp_r == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
endmodule : pgr_fifo

// ====================================================
// Gray receive and interrupt block
module pgr_core #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Serial pins
  input wire logic data_in,
  input wire logic frame_sync_in,
  // Events from the rest of the PCM
  input wire logic receive_error_event_in,
  input wire logic transmit_error_event_in,
  input wire logic [6:0] transmit_fifo_words_in,
  input wire logic pcm_running_in,
  // Interrupt
  output logic irq_out
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  pgr_pkg::pgr_bus_req_t req;
  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // ====================================================
  // Pin synchronisers
  logic [1:0] d_sync_r;
  logic [1:0] s_sync_r;
  logic d_q_r;
  logic s_q_r;
  always_ff @(posedge ref_clk_in) begin
    d_sync_r <= {d_sync_r[0], data_in};
    s_sync_r <= {s_sync_r[0], frame_sync_in};
    d_q_r <= d_sync_r[1];
    s_q_r <= s_sync_r[1];
  end

  // ====================================================
  // Register state
  logic [3:0] interrupt_enable_r;
  logic [3:0] interrupt_status_clear_r;
  logic [3:0] int_nxt;
  logic gray_en_r;
  logic gray_logic_clear_r;
  logic flush_pend_r;
  logic flush_done_r;
  logic [6:0] receive_threshold_r;
  logic [6:0] transmit_threshold_r;
  logic [31:0] shift_r;
  logic [5:0] receive_buffer_bits_r;
  logic [5:0] flushed_r;
  logic [31:0] rdata_r;

  wire wr_en = req.wr && (req.addr == pgr_pkg::ADDR_INT_ENABLE);
  wire wr_st = req.wr && (req.addr == pgr_pkg::ADDR_INT_STATUS);
  wire wr_gr = req.wr && (req.addr == pgr_pkg::ADDR_GRAY_CTRL);
  wire wr_th = req.wr && (req.addr == pgr_pkg::ADDR_THRESH);
  wire rd_dat = req.rd && (req.addr == pgr_pkg::ADDR_RX_DATA);

  // ====================================================
  // Data/strobe decode: a bit arrives when data xor strobe toggles
  wire ds_phase = d_sync_r[1] ^ s_sync_r[1];
  wire ds_phase_q = d_q_r ^ s_q_r;
  wire bit_strobe = gray_en_r && !gray_logic_clear_r && (ds_phase != ds_phase_q);
  wire [31:0] shift_next = {shift_r[30:0], d_sync_r[1]};
  wire word_full = bit_strobe && (receive_buffer_bits_r == pgr_pkg::WORD_BITS - 6'h01);
  wire flush_go = flush_pend_r && !bit_strobe;

  // ====================================================
  // FIFO
  logic f_in_valid;
  logic f_in_ready;
  logic [31:0] f_in_data;
  logic f_out_valid;
  logic [31:0] f_out_data;
  logic [CW-1:0] f_count;
  // Partial word lands from bit zero; upper bits already zero
  assign f_in_valid = word_full || flush_go;
  assign f_in_data = word_full ? shift_next : shift_r;
  pgr_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clr_in(gray_logic_clear_r),
    .in_valid_in(f_in_valid),
    .in_ready_out(f_in_ready),
    .in_data_in(f_in_data),
    .out_valid_out(f_out_valid),
    .out_ready_in(rd_dat),
    .out_data_out(f_out_data),
    .count_out(f_count)
  );
  wire push_ok = f_in_valid && f_in_ready;
  // A push lost to a full FIFO is a receive error
  wire rx_overflow = f_in_valid && !f_in_ready;

  // ====================================================
  // Interrupt events, set wins over clear
  wire [3:0] ev;
  assign ev[pgr_pkg::BIT_RX_ERR] = receive_error_event_in || rx_overflow;
  assign ev[pgr_pkg::BIT_TX_ERR] = transmit_error_event_in;
  assign ev[pgr_pkg::BIT_RX_LVL] = (7'(f_count) >= receive_threshold_r);
  assign ev[pgr_pkg::BIT_TX_LVL] = (transmit_fifo_words_in < transmit_threshold_r);
  always_comb begin
    int_nxt = interrupt_status_clear_r;
    if (wr_st) begin
      int_nxt = int_nxt & ~req.wdata[3:0];
    end
    int_nxt = int_nxt | ev;
  end
  assign irq_out = |(interrupt_status_clear_r & interrupt_enable_r);

  // ====================================================
  // Register writes
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      interrupt_enable_r <= pgr_pkg::INT_RESET;
      interrupt_status_clear_r <= pgr_pkg::INT_RESET;
      receive_threshold_r <= pgr_pkg::RX_THR_RESET;
      transmit_threshold_r <= pgr_pkg::TX_THR_RESET;
      gray_en_r <= 1'b0;
      gray_logic_clear_r <= 1'b0;
    end else begin
      interrupt_status_clear_r <= int_nxt;
      // Writes while running are dropped to protect the enable set
      if (wr_en && !pcm_running_in) begin
        interrupt_enable_r <= req.wdata[3:0];
      end
      if (wr_th) begin
        receive_threshold_r <= req.wdata[6:0];
        transmit_threshold_r <= req.wdata[pgr_pkg::THR_TX_LSB +: 7];
      end
      if (wr_gr) begin
        gray_en_r <= req.wdata[pgr_pkg::GRAY_EN_BIT];
        gray_logic_clear_r <= req.wdata[pgr_pkg::GRAY_CLR_BIT];
      end
    end
  end

  // ====================================================
  // Gray receive buffer
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || gray_logic_clear_r) begin
      shift_r <= '0;
      receive_buffer_bits_r <= '0;
      flushed_r <= '0;
      flush_pend_r <= 1'b0;
      flush_done_r <= 1'b0;
    end else begin
      if (wr_gr && req.wdata[pgr_pkg::GRAY_FLUSH_BIT]) begin
        flush_pend_r <= 1'b1;
      end else if (flush_go) begin
        flush_pend_r <= 1'b0;
      end
      if (wr_gr) begin
        flush_done_r <= 1'b0;
      end else if (flush_go) begin
        flush_done_r <= 1'b1;
      end
      if (word_full) begin
        shift_r <= '0;
        receive_buffer_bits_r <= '0;
      end else if (flush_go) begin
        shift_r <= '0;
        receive_buffer_bits_r <= '0;
        flushed_r <= receive_buffer_bits_r;
      end else if (bit_strobe) begin
        shift_r <= shift_next;
        receive_buffer_bits_r <= receive_buffer_bits_r + 6'h01;
      end
    end
  end

  // ====================================================
  // Read data, one cycle after the strobe
  // Flush bit stays zero until the pending word has been offered to the FIFO, landed or dropped when full
  wire [31:0] gray_view = {10'h000, 6'(f_count), flushed_r, receive_buffer_bits_r, 1'b0,
                           flush_done_r, gray_logic_clear_r, gray_en_r};
  wire [31:0] rd_mux = (req.addr == pgr_pkg::ADDR_INT_ENABLE) ? {28'h0, interrupt_enable_r} :
                       (req.addr == pgr_pkg::ADDR_INT_STATUS) ? {28'h0, interrupt_status_clear_r} :
                       (req.addr == pgr_pkg::ADDR_GRAY_CTRL) ? gray_view :
                       (req.addr == pgr_pkg::ADDR_THRESH) ?
                         {17'h0, transmit_threshold_r, 1'b0, receive_threshold_r} :
                       (rd_dat && f_out_valid) ? f_out_data : 32'h0;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= req.rd ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata_out = rdata_r;

  // ====================================================
  // Checks
  property p_irq_rx;
    @(posedge ref_clk_in) disable iff (rst_in)
      (interrupt_enable_r[3] && receive_error_event_in) |=> irq_out;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("rx error no irq");
  property p_irq_tx;
    @(posedge ref_clk_in) disable iff (rst_in)
      (interrupt_enable_r[2] && transmit_error_event_in) |=> irq_out;
  endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("tx error no irq");
  property p_rx_lvl;
    @(posedge ref_clk_in) disable iff (rst_in)
      (7'(f_count) >= receive_threshold_r) |=> interrupt_status_clear_r[1];
  endproperty
  a_rx_lvl: assert property (p_rx_lvl) else $error("rx level bit missing");
  property p_tx_lvl;
    @(posedge ref_clk_in) disable iff (rst_in)
      (transmit_fifo_words_in < transmit_threshold_r) |=> interrupt_status_clear_r[0];
  endproperty
  a_tx_lvl: assert property (p_tx_lvl) else $error("tx level bit missing");
  property p_w1c;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_st && req.wdata[2] && !transmit_error_event_in) |=> !interrupt_status_clear_r[2];
  endproperty
  a_w1c: assert property (p_w1c) else $error("w1c failed");
  property p_irq_mask;
    @(posedge ref_clk_in) disable iff (rst_in)
      (interrupt_enable_r == 4'h0) |-> !irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  sequence s_full;
    word_full && f_in_ready;
  endsequence
  property p_word;
    @(posedge ref_clk_in) disable iff (rst_in || gray_logic_clear_r)
      s_full |=> (receive_buffer_bits_r == 6'h00) &&
        (f_count == $past(f_count) + CW'(1) - CW'($past(rd_dat && f_out_valid)));
  endproperty
  a_word: assert property (p_word) else $error("word push wrong");
  property p_clr;
    @(posedge ref_clk_in) disable iff (rst_in)
      gray_logic_clear_r |=> (receive_buffer_bits_r == 6'h00) && (f_count == '0);
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");
  property p_flush_busy;
    @(posedge ref_clk_in) disable iff (rst_in)
      flush_pend_r |-> !gray_view[pgr_pkg::GRAY_FLUSH_BIT];
  endproperty
  a_flush_busy: assert property (p_flush_busy) else $error("flush bit set while busy");
  sequence s_flush;
    flush_go && f_in_ready;
  endsequence
  property p_flush;
    @(posedge ref_clk_in) disable iff (rst_in || gray_logic_clear_r)
      s_flush |=> (receive_buffer_bits_r == 6'h00) && (flushed_r == $past(receive_buffer_bits_r));
  endproperty
  a_flush: assert property (p_flush) else $error("flush count wrong");
  property p_pad;
    @(posedge ref_clk_in) disable iff (rst_in)
      flush_go |-> ((f_in_data >> receive_buffer_bits_r) == 32'h0);
  endproperty
  a_pad: assert property (p_pad) else $error("flush word not zero padded");
  sequence s_idle_rx;
    !gray_en_r && !flush_go;
  endsequence
  property p_gray_off;
    @(posedge ref_clk_in) disable iff (rst_in || gray_logic_clear_r)
      s_idle_rx |=> (receive_buffer_bits_r == $past(receive_buffer_bits_r));
  endproperty
  a_gray_off: assert property (p_gray_off) else $error("bits counted while gray off");
  property p_w0;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_st && (req.wdata[3:0] == 4'h0)) |=>
        ((interrupt_status_clear_r & $past(interrupt_status_clear_r)) == $past(interrupt_status_clear_r));
  endproperty
  a_w0: assert property (p_w0) else $error("zero write cleared a status bit");
  property p_count;
    @(posedge ref_clk_in) disable iff (rst_in || gray_logic_clear_r)
      (bit_strobe && !word_full) |=> (receive_buffer_bits_r == $past(receive_buffer_bits_r) + 6'h01);
  endproperty
  a_count: assert property (p_count) else $error("bit count not advanced");
endmodule : pgr_core

/* File: testbench/pcm_interrupt_and_gray_receive_test.sv */
module pcm_interrupt_and_gray_receive_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic data_pin;
  logic strobe_pin;
  logic send = 1'b0;
  logic sbit = 1'b0;
  logic rx_err = 1'b0;
  logic tx_err = 1'b0;
  logic running = 1'b0;
  logic [6:0] tx_words = 7'h05;
  logic irq;
  int err_count = 0;
  int samples_checked = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  pgr_core #(.FIFO_DEPTH(4)) DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .data_in(data_pin),
    .frame_sync_in(strobe_pin), .receive_error_event_in(rx_err), .transmit_error_event_in(tx_err),
    .transmit_fifo_words_in(tx_words), .pcm_running_in(running), .irq_out(irq));
  pgr_ds_source SRC (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .send_in(send), .bit_in(sbit),
    .data_out(data_pin), .strobe_out(strobe_pin));
  // ====================================================
  // Bus tasks and compares
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1;
    samples_checked++;
    if ((rdata & m) !== e) begin
      err_count++;
      $display("BAD %0t read %h got %h exp %h", $time, a, rdata & m, e);
    end
  endtask : chk_reg
  task automatic chk_irq(input logic e);
    #2;
    samples_checked++;
    if (irq !== e) begin
      err_count++;
      $display("BAD %0t irq got %b exp %b", $time, irq, e);
    end
  endtask : chk_irq
  // Spacing leaves room for the pin synchroniser and bit counter
  task automatic send_bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk_in);
      send <= 1'b1;
      sbit <= v[i];
      @(posedge ref_clk_in);
      send <= 1'b0;
      repeat (5) @(posedge ref_clk_in);
    end
  endtask : send_bits
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    #200us;
    err_count++;
    final_report();
  end
  // ====================================================
  // Tests
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    chk_reg(8'h00, 32'hFFFFFFFF, 32'h0);
    chk_reg(8'h04, 32'hFFFFFFFF, 32'h0);
    chk_reg(8'h08, 32'hFFFFFFFF, 32'h0);
    chk_reg(8'h0C, 32'hFFFFFFFF, 32'h00000101);
    chk_reg(8'h20, 32'hFFFFFFFF, 32'h0);
    @(posedge ref_clk_in);
    running <= 1'b1;
    wr_reg(8'h00, 32'hF);
    chk_reg(8'h00, 32'hF, 32'h0);
    @(posedge ref_clk_in);
    running <= 1'b0;
    wr_reg(8'h00, 32'hF);
    chk_reg(8'h00, 32'hF, 32'hF);
    @(posedge ref_clk_in);
    rx_err <= 1'b1;
    tx_err <= 1'b1;
    @(posedge ref_clk_in);
    rx_err <= 1'b0;
    tx_err <= 1'b0;
    chk_reg(8'h04, 32'hF, 32'hC);
    chk_irq(1'b1);
    wr_reg(8'h04, 32'h4);
    chk_reg(8'h04, 32'hF, 32'h8);
    wr_reg(8'h04, 32'h0);
    chk_reg(8'h04, 32'hF, 32'h8);
    wr_reg(8'h04, 32'h8);
    chk_reg(8'h04, 32'hF, 32'h0);
    chk_irq(1'b0);
    @(posedge ref_clk_in);
    tx_words <= 7'h00;
    chk_reg(8'h04, 32'hF, 32'h1);
    @(posedge ref_clk_in);
    tx_words <= 7'h05;
    wr_reg(8'h04, 32'h1);
    chk_reg(8'h04, 32'hF, 32'h0);
    send_bits(32'h1, 1);
    chk_reg(8'h08, 32'hFFFFFFFF, 32'h0);
    wr_reg(8'h08, 32'h1);
    send_bits(32'hA5C30F96, 32);
    chk_reg(8'h08, 32'hFFFFFFFF, 32'h00010001);
    chk_reg(8'h04, 32'hF, 32'h2);
    chk_reg(8'h10, 32'hFFFFFFFF, 32'hA5C30F96);
    wr_reg(8'h04, 32'h2);
    send_bits(32'h16, 5);
    chk_reg(8'h08, 32'hFFFFFFFF, 32'h00000051);
    wr_reg(8'h08, 32'h5);
    repeat (20) @(posedge ref_clk_in);
    chk_reg(8'h08, 32'hFFFFFFFF, 32'h00011405);
    chk_reg(8'h08, 32'h4, 32'h4);
    chk_reg(8'h10, 32'hFFFFFFFF, 32'h00000016);
    for (int w = 0; w < 5; w++) begin
      send_bits(32'h12345678 + w, 32);
    end
    chk_reg(8'h08, 32'h003F0000, 32'h00040000);
    chk_reg(8'h04, 32'h8, 32'h8);
    chk_irq(1'b1);
    wr_reg(8'h00, 32'h0);
    chk_irq(1'b0);
    send_bits(32'h3, 2);
    chk_reg(8'h08, 32'h000003F0, 32'h00000020);
    wr_reg(8'h08, 32'h3);
    chk_reg(8'h08, 32'h003F03F7, 32'h00000003);
    wr_reg(8'h08, 32'h1);
    chk_reg(8'h08, 32'h003F03F7, 32'h00000001);
    final_report();
  end
endmodule : pcm_interrupt_and_gray_receive_test

/* File: testbench/pgr_ds_source.sv */
module pgr_ds_source (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Bit request
  input wire logic send_in,
  input wire logic bit_in,
  // Serial pins
  output logic data_out,
  output logic strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================================
  // Data/strobe encoder
  // One line moves per bit, so the two pins never switch together
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      data_out <= 1'b0;
      strobe_out <= 1'b0;
    end else if (send_in) begin
      data_out <= bit_in;
      strobe_out <= strobe_out ^ (bit_in == data_out);
    end
  end
endmodule : pgr_ds_source
